// ===== rtl/stt_timer.v
// standard timer with counter, compare a/p, capture and pwm output
//
// Notes on behaviour
// R1 - clock field picks counter clock source
// R2 - on rise clears counter; off holds it
// R3 - on rise resets pin to initial level
// R4 - wide version: control0 bits 2..0 read zero
// R5 - mode field: compare, capture, pwm, timer
// R6 - software stops timer before changing mode
// R7 - compare a match: keep, low, high, toggle
// R8 - pwm function: inactive, active, pwm, pulse
// R9 - capture on rise, fall, both, none
// R10 - requested level equal initial shows no change
// R11 - pwm function changed only while off
// R12 - initial level bit sets starting pin level
// R13 - initial level bit selects pwm active level
// R14 - invert bit flips pin except timer mode; here capture mode also holds the pin low and undriven
// R15 - swap bit exchanges period and duty roles
// R16 - clear select: compare a, else p/overflow
// R17 - overflow clear only with compare p zero
// R18 - clear select ignored outside compare/timer
// R19 - counter readable as low/high bytes
// R20 - compare a in low/high bytes, reset zero
// R21 - pause freezes counter, resume continues
// R22 - compare p matches counter top bits
// R23 - only compare a changes compare output
// R24 - counter steps once per active tick
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module stt_timer
#(
    parameter CNT_W  = 16,
    parameter CP_W   = 8,
    parameter ADDR_W = 8
)
(
    // clock and reset
    input  wire              ref_clk_in,
    input  wire              sys_rst_in,
    // apb slave
    input  wire              psel_in,
    input  wire              penable_in,
    input  wire              pwrite_in,
    input  wire [ADDR_W-1:0] paddr_in,
    input  wire [31:0]       pwdata_in,
    output reg  [31:0]       prdata_out,
    output reg               pready_out,
    output reg               pslverr_out,
    // pins
    input  wire              sub_internal_clock_in,
    input  wire              external_count_clock_pin_in,
    input  wire              capture_input_pin_in,
    output reg               timer_output_pin_out,
    output reg               timer_output_en_out
);
`include "stt_defines.vh"

    // short version keeps compare p inside control0
    localparam P_IN_CTRL = (CP_W <= 3);
    localparam LOW_W     = CNT_W - CP_W;

    reg [7:0]       ctrl0_reg;
    reg [7:0]       ctrl1_reg;
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] cnt_next;
    reg [CNT_W-1:0] cmpa_reg;
    reg [CP_W-1:0]  cmpp_reg;
    reg [CNT_W-1:0] cap_reg;
    reg [2:0]       flag_reg;
    reg [2:0]       flag_next;
    reg             on_q_reg;
    reg             lvl_reg;
    reg             lvl_next;
    reg [2:0]       cap_sync_reg;
    reg [31:0]      rd_next;
    reg             map_next;
    reg             clear_now;

    wire            tick;
    wire [15:0]     cnt_pad;
    wire [15:0]     cmpa_pad;
    wire [CNT_W-1:0] cnt_inc;
    wire [1:0]      mode;
    wire [1:0]      func;
    wire            init_lvl;
    wire            step;
    wire            on_rise;
    wire            a_hit;
    wire            p_hit;
    wire            pwm_active;
    wire            cap_rise;
    wire            cap_fall;
    reg             cap_take;
    wire            wr_en;
    wire [ADDR_W-1:0] addr;

    assign mode     = ctrl1_reg[`STT_C1_MODE_HI:`STT_C1_MODE_LO];
    assign func     = ctrl1_reg[`STT_C1_FUNC_HI:`STT_C1_FUNC_LO];
    assign init_lvl = ctrl1_reg[`STT_C1_INIT];
    assign on_rise  = ctrl0_reg[`STT_C0_ON] & ~on_q_reg; // R2
    assign step     = ctrl0_reg[`STT_C0_ON] & ~ctrl0_reg[`STT_C0_PAUSE]
                      & tick & ~on_rise; // R21 R24
    assign cnt_inc  = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    assign cnt_pad  = {{(16-CNT_W){1'b0}}, cnt_reg};
    assign cmpa_pad = {{(16-CNT_W){1'b0}}, cmpa_reg};

    // a zero compare a never matches; counter just wraps
    assign a_hit = step & (cmpa_reg != {CNT_W{1'b0}})
                   & (cnt_inc == cmpa_reg);
    // compare p zero matches only when the counter wraps to zero
    assign p_hit = step & (cnt_inc[CNT_W-1:LOW_W] == cmpp_reg)
                   & (cnt_inc[LOW_W-1:0] == {LOW_W{1'b0}}); // R22 R17

    // duty held against the present count; duty >= period gives 100%
    assign pwm_active = ctrl1_reg[`STT_C1_SWAP] ?
        ((cmpp_reg == {CP_W{1'b0}}) |
         (cnt_reg < {cmpp_reg, {LOW_W{1'b0}}})) :
        (cnt_reg < cmpa_reg); // R15

    assign cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2];
    assign cap_fall = ~cap_sync_reg[1] & cap_sync_reg[2];

    assign addr  = paddr_in;
    assign wr_en = psel_in & penable_in & pready_out & pwrite_in;

    stt_tick u_tick
    (
        .ref_clk_in                  (ref_clk_in),
        .sys_rst_in                  (sys_rst_in),
        .clock_source_select_in
            (ctrl0_reg[`STT_C0_CLK_HI:`STT_C0_CLK_LO]),
        .sub_internal_clock_in       (sub_internal_clock_in),
        .external_count_clock_pin_in (external_count_clock_pin_in),
        .tick_out                    (tick)
    );

    // counter clear source by mode
    always @*
    begin
        case (mode) // R5
            `STT_MODE_CMP,
            `STT_MODE_TMR: clear_now = ctrl1_reg[`STT_C1_CLR] ?
                                       a_hit : p_hit; // R16
            `STT_MODE_PWM: clear_now = ctrl1_reg[`STT_C1_SWAP] ?
                                       a_hit : p_hit; // R15 R18
            `STT_MODE_CAP: clear_now = p_hit; // R18
            default:       clear_now = 1'b0;
        endcase
    end

    always @*
    begin
        if (on_rise)
            cnt_next = {CNT_W{1'b0}}; // R2
        else if (step)
            cnt_next = clear_now ? {CNT_W{1'b0}} : cnt_inc; // R24
        else
            cnt_next = cnt_reg; // R2 R21
    end

    // capture edge choice
    always @*
    begin
        case (func) // R9
            `STT_FN_0: cap_take = cap_rise;
            `STT_FN_1: cap_take = cap_fall;
            `STT_FN_2: cap_take = cap_rise | cap_fall;
            `STT_FN_3: cap_take = 1'b0;
            default:   cap_take = 1'b0;
        endcase
    end

    // internal pin level before inversion
    always @*
    begin
        lvl_next = lvl_reg;
        if (on_rise &&
            (mode == `STT_MODE_CMP || mode == `STT_MODE_PWM))
            lvl_next = init_lvl; // R3 R12
        else if (ctrl0_reg[`STT_C0_ON] && mode == `STT_MODE_CMP)
        begin
            // only compare a moves the pin; matching the current
            // level leaves it where it is
            if (a_hit) // R23
            begin
                case (func) // R7 R10
                    `STT_FN_0: lvl_next = lvl_reg;
                    `STT_FN_1: lvl_next = 1'b0;
                    `STT_FN_2: lvl_next = 1'b1;
                    `STT_FN_3: lvl_next = ~lvl_reg;
                    default:   lvl_next = lvl_reg;
                endcase
            end
        end
        else if (ctrl0_reg[`STT_C0_ON] && mode == `STT_MODE_PWM)
        begin
            case (func) // R8 R13
                `STT_FN_0: lvl_next = ~init_lvl;
                `STT_FN_1: lvl_next = init_lvl;
                `STT_FN_2: lvl_next = pwm_active ? init_lvl : ~init_lvl;
                `STT_FN_3: lvl_next = a_hit ? ~init_lvl : lvl_reg;
                default:   lvl_next = lvl_reg;
            endcase
        end
    end

    // sticky flags: hardware set beats a software clear
    always @*
    begin
        flag_next = flag_reg;
        if (wr_en && addr == `STT_OFS_STATUS)
            flag_next = flag_reg & ~pwdata_in[2:0];
        if (a_hit)
            flag_next[`STT_ST_A] = 1'b1;
        if (p_hit && !(ctrl1_reg[`STT_C1_CLR] &&
            (mode == `STT_MODE_CMP || mode == `STT_MODE_TMR)))
            flag_next[`STT_ST_P] = 1'b1;
        if (cap_take && ctrl0_reg[`STT_C0_ON] && mode == `STT_MODE_CAP)
            flag_next[`STT_ST_CAP] = 1'b1;
    end

    // read mux; data is sampled in the setup cycle
    always @*
    begin
        rd_next  = 32'h0000_0000;
        map_next = 1'b1;
        case (addr)
            `STT_OFS_CTRL0:
            begin
                rd_next[7:3] = ctrl0_reg[7:3];
                if (P_IN_CTRL)
                    rd_next[CP_W-1:0] = cmpp_reg;
                // wide version: low control0 bits read zero
            end
            `STT_OFS_CTRL1:   rd_next[7:0] = ctrl1_reg;
            `STT_OFS_CNT_LO:  rd_next[7:0] = cnt_pad[7:0]; // R19
            `STT_OFS_CNT_HI:  rd_next[7:0] = cnt_pad[15:8]; // R19
            `STT_OFS_CMPA_LO: rd_next[7:0] = cmpa_pad[7:0]; // R20
            `STT_OFS_CMPA_HI: rd_next[7:0] = cmpa_pad[15:8]; // R20
            `STT_OFS_CMPP:
            begin
                if (!P_IN_CTRL)
                    rd_next[CP_W-1:0] = cmpp_reg;
            end
            `STT_OFS_STATUS:  rd_next[2:0] = flag_reg;
            `STT_OFS_CAPTURE: rd_next[CNT_W-1:0] = cap_reg;
            default:          map_next = 1'b0;
        endcase
    end

    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl0_reg            <= 8'h00;
            ctrl1_reg            <= 8'h00;
            cnt_reg              <= {CNT_W{1'b0}};
            cmpa_reg             <= {CNT_W{1'b0}}; // R20
            cmpp_reg             <= {CP_W{1'b0}};
            cap_reg              <= {CNT_W{1'b0}};
            flag_reg             <= 3'h0;
            on_q_reg             <= 1'b0;
            lvl_reg              <= 1'b0;
            cap_sync_reg         <= 3'h0;
            prdata_out           <= 32'h0000_0000;
            pready_out           <= 1'b0;
            pslverr_out          <= 1'b0;
            timer_output_pin_out <= 1'b0;
            timer_output_en_out  <= 1'b0;
        end
        else
        begin
            on_q_reg     <= ctrl0_reg[`STT_C0_ON];
            cnt_reg      <= cnt_next;
            lvl_reg      <= lvl_next;
            flag_reg     <= flag_next;
            cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin_in};
            if (cap_take && ctrl0_reg[`STT_C0_ON] &&
                mode == `STT_MODE_CAP)
                cap_reg <= cnt_reg; // R9
            // one wait-free access cycle after every setup
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~map_next;
            if (psel_in && !penable_in)
                prdata_out <= rd_next;
            if (wr_en)
            begin
                case (addr)
                    `STT_OFS_CTRL0:
                    begin
                        ctrl0_reg <= {pwdata_in[7:3], 3'h0}; // R4
                        if (P_IN_CTRL)
                            cmpp_reg <= pwdata_in[CP_W-1:0];
                    end
                    `STT_OFS_CTRL1:   ctrl1_reg <= pwdata_in[7:0];
                    `STT_OFS_CMPA_LO: cmpa_reg[7:0] <= pwdata_in[7:0];
                    `STT_OFS_CMPA_HI:
                        cmpa_reg[CNT_W-1:8] <= pwdata_in[CNT_W-9:0];
                    `STT_OFS_CMPP:
                    begin
                        if (!P_IN_CTRL)
                            cmpp_reg <= pwdata_in[CP_W-1:0];
                    end
                    default:          ctrl1_reg <= ctrl1_reg;
                endcase
            end
            // timer and capture modes leave the pin undriven
            if (mode == `STT_MODE_CMP || mode == `STT_MODE_PWM)
            begin
                timer_output_pin_out <= lvl_reg ^
                                        ctrl1_reg[`STT_C1_INV]; // R14
                timer_output_en_out  <= 1'b1;
            end
            else
            begin
                timer_output_pin_out <= 1'b0;
                timer_output_en_out  <= 1'b0;
            end
        end
    end

endmodule

// ===== rtl/stt_defines.vh
// constants for the standard timer: offsets, fields, codes
`ifndef STT_DEFINES_VH
`define STT_DEFINES_VH

// apb byte offsets
`define STT_OFS_CTRL0      8'h00
`define STT_OFS_CTRL1      8'h04
`define STT_OFS_CNT_LO     8'h08
`define STT_OFS_CNT_HI     8'h0C
`define STT_OFS_CMPA_LO    8'h10
`define STT_OFS_CMPA_HI    8'h14
`define STT_OFS_CMPP       8'h18
`define STT_OFS_STATUS     8'h1C
`define STT_OFS_CAPTURE    8'h20

// timer_mode_clock_on (ctrl0) fields
`define STT_C0_PAUSE       7
`define STT_C0_CLK_HI      6
`define STT_C0_CLK_LO      4
`define STT_C0_ON          3

// timer_mode_output_control (ctrl1) fields
`define STT_C1_MODE_HI     7
`define STT_C1_MODE_LO     6
`define STT_C1_FUNC_HI     5
`define STT_C1_FUNC_LO     4
`define STT_C1_INIT        3
`define STT_C1_INV         2
`define STT_C1_SWAP        1
`define STT_C1_CLR         0

// status flag positions
`define STT_ST_A           0
`define STT_ST_P           1
`define STT_ST_CAP         2

// operating modes
`define STT_MODE_CMP       2'h0
`define STT_MODE_CAP       2'h1
`define STT_MODE_PWM       2'h2
`define STT_MODE_TMR       2'h3

// output function codes
`define STT_FN_0           2'h0
`define STT_FN_1           2'h1
`define STT_FN_2           2'h2
`define STT_FN_3           2'h3

// clock source codes
`define STT_CK_SYS4        3'h0
`define STT_CK_SYS         3'h1
`define STT_CK_H16         3'h2
`define STT_CK_H64         3'h3
`define STT_CK_SUB0        3'h4
`define STT_CK_SUB1        3'h5
`define STT_CK_EXTR        3'h6
`define STT_CK_EXTF        3'h7

// prescaler terminal counts
`define STT_PRE_W          6
`define STT_PRE_DIV4       2'h3
`define STT_PRE_DIV16      4'hF
`define STT_PRE_DIV64      6'h3F

`endif

// ===== rtl/stt_tick.v
// timer clock source selection, prescaler and pin edge detection
`timescale 1ns/1ps
module stt_tick
(
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       sys_rst_in,
    // source select
    input  wire [2:0] clock_source_select_in,
    // asynchronous clock pins
    input  wire       sub_internal_clock_in,
    input  wire       external_count_clock_pin_in,
    // one-cycle count enable
    output reg        tick_out
);
`include "stt_defines.vh"

    reg [`STT_PRE_W-1:0] pre_reg;
    reg [2:0]            sub_sync_reg;
    reg [2:0]            ext_sync_reg;
    reg                  tick_next;

    // sub and external pins are asynchronous: two flops, then a
    // third stage only for the edge compare
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            pre_reg      <= {`STT_PRE_W{1'b0}};
            sub_sync_reg <= 3'h0;
            ext_sync_reg <= 3'h0;
            tick_out     <= 1'b0;
        end
        else
        begin
            pre_reg      <= pre_reg + 6'h01;
            sub_sync_reg <= {sub_sync_reg[1:0], sub_internal_clock_in};
            ext_sync_reg <= {ext_sync_reg[1:0],
                             external_count_clock_pin_in};
            tick_out     <= tick_next;
        end
    end

    // high clock is taken as the system clock here
    always @*
    begin
        case (clock_source_select_in) // R1
            `STT_CK_SYS4: tick_next = (pre_reg[1:0] == `STT_PRE_DIV4);
            `STT_CK_SYS:  tick_next = 1'b1;
            `STT_CK_H16:  tick_next = (pre_reg[3:0] == `STT_PRE_DIV16);
            `STT_CK_H64:  tick_next = (pre_reg == `STT_PRE_DIV64);
            `STT_CK_SUB0,
            `STT_CK_SUB1: tick_next = sub_sync_reg[1] & ~sub_sync_reg[2];
            `STT_CK_EXTR: tick_next = ext_sync_reg[1] & ~ext_sync_reg[2];
            `STT_CK_EXTF: tick_next = ~ext_sync_reg[1] & ext_sync_reg[2];
            default:      tick_next = 1'b0;
        endcase
    end

endmodule

// ===== testbench/stt_timer_monitor.sv
// concurrent checks on the timer's bus and pin ports
`timescale 1ns/1ps
module stt_timer_monitor
#(
    parameter ADDR_W = 8
)
(
    // clock and reset
    input wire              ref_clk_in,
    input wire              sys_rst_in,
    // apb
    input wire              psel_in,
    input wire              penable_in,
    input wire              pwrite_in,
    input wire [ADDR_W-1:0] paddr_in,
    input wire [31:0]       pwdata_in,
    input wire [31:0]       prdata_out,
    input wire              pready_out,
    input wire              pslverr_out,
    // pins
    input wire              sub_internal_clock_in,
    input wire              external_count_clock_pin_in,
    input wire              capture_input_pin_in,
    input wire              timer_output_pin_out,
    input wire              timer_output_en_out
);
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire setup = psel_in && !penable_in;
    wire rd_done = pready_out && !pwrite_in;

    ready_after_setup_a: assert property (setup |=> pready_out)
        else $error("no ready after setup");
    ready_pulse_a: assert property
        (pready_out |-> (psel_in && penable_in) ##1 !pready_out)
        else $error("ready outside one access cycle");
    err_unmapped_a: assert property
        (setup && paddr_in > 'h20 |=> pslverr_out)
        else $error("unmapped address not refused");
    err_mapped_a: assert property
        (setup && paddr_in <= 'h20 && paddr_in[1:0] == 2'b00
         |=> !pslverr_out)
        else $error("mapped address refused");
    err_with_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    ctrl0_low_zero_a: assert property
        (rd_done && paddr_in == 'h00 |-> prdata_out[2:0] == 3'h0)
        else $error("unused control bits not zero");
    byte_regs_a: assert property
        (rd_done && paddr_in != 'h20 |-> prdata_out[31:8] == 24'h00_0000)
        else $error("byte register upper bits set");
    rdata_stands_a: assert property
        (pready_out ##1 !setup |-> $stable(prdata_out))
        else $error("read data moved before next setup");
    pin_idle_low_a: assert property
        (!timer_output_en_out |-> !timer_output_pin_out)
        else $error("pin driven high while disabled");
endmodule

bind stt_timer stt_timer_monitor #(.ADDR_W(ADDR_W)) u_mon
(
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .sub_internal_clock_in(sub_internal_clock_in),
    .external_count_clock_pin_in(external_count_clock_pin_in),
    .capture_input_pin_in(capture_input_pin_in),
    .timer_output_pin_out(timer_output_pin_out),
    .timer_output_en_out(timer_output_en_out)
);

// ===== testbench/stt_far_side.sv
// pin-side model: sub clock, external count clock, capture input
`timescale 1ns/1ps
module stt_far_side
(
    // clock
    input  wire  ref_clk_in,
    // pins
    output logic sub_clk_out,
    output logic ext_clk_out,
    output logic cap_pin_out
);
    logic [3:0] div_reg = 4'h0;

    initial sub_clk_out = 1'b0;
    initial ext_clk_out = 1'b0;
    initial cap_pin_out = 1'b0;

    // sub clock is an internal oscillator, so it runs free
    always @(posedge ref_clk_in)
    begin
        div_reg <= div_reg + 4'h1;
        if (div_reg == 4'h7)
            sub_clk_out <= !sub_clk_out;
    end

    // slow pulses so the two-stage synchroniser sees every edge
    task pulses(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge ref_clk_in);
            ext_clk_out <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            ext_clk_out <= 1'b0;
        end
    endtask

    // one level change on the capture pin, just after a clock edge
    task cap_edge(input logic v);
        @(posedge ref_clk_in);
        cap_pin_out <= v;
    endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the standard timer
`timescale 1ns/1ps
module tb_top;
    typedef struct packed
    {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic       r;
    } stt_row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic        err;
    logic [31:0] c;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         pin;
    wire         pin_en;
    wire         sub_clk;
    wire         ext_clk;
    wire         cap_pin;
    int          bad_count = 0;
    int          n_tests = 0;
    stt_row_t    rows [0:14] = '{
        '{0, 8'h00, 8'h00, 8'h00, 0}, '{0, 8'h04, 8'h00, 8'h00, 0},
        '{0, 8'h08, 8'h00, 8'h00, 0}, '{0, 8'h0C, 8'h00, 8'h00, 0},
        '{0, 8'h10, 8'h00, 8'h00, 0}, '{0, 8'h14, 8'h00, 8'h00, 0},
        '{1, 8'h00, 8'h07, 8'h00, 0}, '{0, 8'h00, 8'h00, 8'h00, 0},
        '{1, 8'h04, 8'hA5, 8'h00, 0}, '{0, 8'h04, 8'h00, 8'hA5, 0},
        '{1, 8'h08, 8'hFF, 8'h00, 0}, '{0, 8'h08, 8'h00, 8'h00, 0},
        '{1, 8'h10, 8'h34, 8'h00, 0}, '{0, 8'h10, 8'h00, 8'h34, 0},
        '{0, 8'h40, 8'h00, 8'h00, 1}};

    always #4 clk = ~clk;

    stt_timer dut
    (
        .ref_clk_in(clk), .sys_rst_in(rst),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .sub_internal_clock_in(sub_clk),
        .external_count_clock_pin_in(ext_clk),
        .capture_input_pin_in(cap_pin),
        .timer_output_pin_out(pin), .timer_output_en_out(pin_en)
    );

    stt_far_side far
    (
        .ref_clk_in(clk), .sub_clk_out(sub_clk),
        .ext_clk_out(ext_clk), .cap_pin_out(cap_pin)
    );

    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // one apb transfer; waits for ready, never assumes its latency
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50)
            bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_count(input int w);
        repeat (w) @(posedge clk);
        apb(1'b0, 8'h08, 8'h00);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[j])
        begin
            apb(rows[j].w, rows[j].a, rows[j].d);
            chk("slverr", 32'(rows[j].r), 32'(err));
            if (!rows[j].w)
                chk("read", 32'(rows[j].e), rd);
        end
        apb(1'b1, 8'h10, 8'd20);
        // compare mode, clear on a: function x initial level
        // one match only by the second look, so a toggle shows
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 8'h00, 8'h10);
            apb(1'b1, 8'h04, {2'b00, 2'(k % 4), 1'(k / 4), 3'b001});
            apb(1'b1, 8'h00, 8'h18);
            repeat (6) @(posedge clk);
            chk("pin init", 32'(k / 4), 32'(pin));
            repeat (30) @(posedge clk);
            c = (k % 4 == 0) ? k / 4 : (k % 4 == 3) ? 1 - k / 4 : k % 4 / 2;
            chk("pin match", c, 32'(pin));
            chk("pin en", 32'h0000_0001, 32'(pin_en));
        end
        rd_count(0);
        chk("below a", 32'h0000_0001, 32'(rd < 32'd20));
        // pwm forced levels: function x active level x invert
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 8'h00, 8'h10);
            apb(1'b1, 8'h04, {3'b100, k[0], k[1], k[2], 2'b00});
            apb(1'b1, 8'h00, 8'h18);
            repeat (8) @(posedge clk);
            chk("pwm level", 32'((k[0] ? k[1] : !k[1]) ^ k[2]), 32'(pin));
        end
        // external pin clock, both edges, with pause and off
        apb(1'b1, 8'h00, 8'h10);
        apb(1'b1, 8'h04, 8'hC0);
        for (int s = 6; s < 8; s++)
        begin
            c = 32'(s) << 4;
            apb(1'b1, 8'h00, c[7:0]);
            apb(1'b1, 8'h00, c[7:0] | 8'h08);
            far.pulses(3);
            rd_count(10);
            chk("ext count", 32'd3, rd);
            chk("pin en", 32'h0000_0000, 32'(pin_en));
            apb(1'b1, 8'h00, c[7:0] | 8'h88);
            far.pulses(2);
            rd_count(10);
            chk("paused", 32'd3, rd);
            apb(1'b1, 8'h00, c[7:0] | 8'h08);
            far.pulses(2);
            rd_count(10);
            chk("resumed", 32'd5, rd);
            apb(1'b1, 8'h00, c[7:0]);
            far.pulses(2);
            rd_count(10);
            chk("held off", 32'd5, rd);
            apb(1'b1, 8'h00, c[7:0] | 8'h08);
            rd_count(4);
            chk("cleared on", 32'd0, rd);
        end
        // prescaled and sub clock sources; edge phase unknown, so a band
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h00, 8'h08);
        rd_count(100);
        chk("div4 count", 32'h0000_0001, 32'(rd >= 23 && rd <= 27));
        apb(1'b1, 8'h00, 8'h40);
        apb(1'b1, 8'h00, 8'h48);
        rd_count(100);
        chk("sub count", 32'h0000_0001, 32'(rd >= 2 && rd <= 4));
        // pwm with compare p period and compare a duty, then one pulse
        apb(1'b1, 8'h18, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, 8'h00, 8'h10);
            apb(1'b1, 8'h04, k ? 8'hB8 : 8'hA8);
            apb(1'b1, 8'h00, 8'h18);
            repeat (10) @(posedge clk);
            chk("pwm start", 32'h0000_0001, 32'(pin));
            repeat (50) @(posedge clk);
            chk("pwm duty end", 32'h0000_0000, 32'(pin));
            repeat (210) @(posedge clk);
            chk("pwm next period", 32'(!k), 32'(pin));
        end
        // capture on rising edge only, then clear its flag
        apb(1'b1, 8'h00, 8'h10);
        apb(1'b1, 8'h04, 8'h40);
        apb(1'b1, 8'h00, 8'h18);
        repeat (50) @(posedge clk);
        far.cap_edge(1'b1);
        repeat (10) @(posedge clk);
        apb(1'b0, 8'h20, 8'h00);
        chk("captured", 32'h0000_0001, 32'(rd >= 45 && rd <= 60));
        apb(1'b0, 8'h1C, 8'h00);
        chk("capture flag", 32'h0000_0001, 32'(rd[2]));
        apb(1'b1, 8'h1C, 8'h04);
        far.cap_edge(1'b0);
        repeat (10) @(posedge clk);
        apb(1'b0, 8'h1C, 8'h00);
        chk("no fall capture", 32'h0000_0000, 32'(rd[2]));
        finish_test;
    end
endmodule
